/* File: pic_ctrl.sv */
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
module pic_ctrl (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // request sources
    input  wire logic        i_ext_irq_in_zero,
    input  wire logic        i_ext_irq_in_one,
    input  wire logic        i_timer0_overflow_flag,
    input  wire logic        i_timer1_overflow_flag,
    input  wire logic        i_pwm_unit_zero,
    input  wire logic        i_pwm_unit_one,
    input  wire logic        i_conversion_done,
    // core side
    output logic             o_core_irq,
    output logic [15:0]      o_core_vector,
    output logic [2:0]       o_core_src,
    input  wire logic        i_core_take,
    input  wire logic        i_core_reti,
    output logic             o_irq
);
    import pic_pkg::*;

    logic [7:0]  irq_enable_reg_r;
    logic [6:0]  priority_low_bit_r;
    logic [6:0]  priority_high_bit_r;
    logic [3:0]  in_service_r;
    logic        conversion_done_flag_r;
    logic [6:0]  status_r;
    logic [6:0]  mask_r;
    logic [1:0]  ext_sync;
    logic [6:0]  raw_req;
    logic [6:0]  gated_req;
    logic [6:0]  req_prev_r;
    pic_grant_t  grant;
    pic_bus_req_t dph_r;
    logic        wr_en;
    logic        rd_status;
    logic        global_irq_enable;

    // external pins cross into the clock domain first
    pic_sync #(.W(2)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   ({i_ext_irq_in_one, i_ext_irq_in_zero}),
        .o_sync    (ext_sync)
    );

    assign raw_req = {conversion_done_flag_r, i_pwm_unit_one, i_pwm_unit_zero,
                      i_timer1_overflow_flag, ext_sync[1], i_timer0_overflow_flag,
                      ext_sync[0]};
    assign global_irq_enable = irq_enable_reg_r[PIC_GLOBAL_EN];
    assign gated_req = global_irq_enable ? (raw_req & irq_enable_reg_r[6:0])
                                         : 7'h00;

    pic_arbiter #(.NSRC(PIC_NSRC)) u_arb (
        .i_req     (gated_req),
        .i_prio_hi (priority_high_bit_r),
        .i_prio_lo (priority_low_bit_r),
        .o_grant   (grant)
    );

    // true when lvl is above every level currently in service, or none is
    function automatic logic above_service(input logic [3:0] ins, input logic [1:0] lvl);
        logic ok;
        ok = 1'b1;
        for (int l = 0; l < PIC_NLVL; l++) begin
            if (ins[l] && (l >= int'(lvl))) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : above_service

    always_comb begin
        o_core_irq = grant.valid && above_service(in_service_r, grant.level);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_core_vector <= 16'h0000;
            o_core_src    <= 3'h0;
        end else begin
            o_core_vector <= grant.vector;
            o_core_src    <= grant.src;
        end
    end

    // one bit per level in service, cleared top down by return
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            in_service_r <= 4'h0;
        end else if (i_core_take && o_core_irq) begin
            in_service_r[grant.level] <= 1'b1;
        end else if (i_core_reti) begin
            for (int l = PIC_NLVL - 1; l >= 0; l--) begin
                if (in_service_r[l] && (in_service_r >> (l + 1)) == 4'h0) begin
                    in_service_r[l] <= 1'b0;
                end
            end
        end
    end

    // ahb address phase captured for the data phase
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            dph_r <= '0;
        end else if (i_hready) begin
            dph_r.sel   <= i_hsel && (i_htrans == PIC_HTRANS_NS);
            dph_r.write <= i_hwrite;
            dph_r.addr  <= i_haddr[11:0];
        end
    end

    assign wr_en     = dph_r.sel && dph_r.write;
    assign rd_status = dph_r.sel && !dph_r.write && (dph_r.addr == PIC_A_STATUS);
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    always_comb begin
        o_hrdata = 32'h0;
        if (dph_r.sel && !dph_r.write) begin
            if (dph_r.addr == PIC_A_IEN) begin
                o_hrdata[7:0] = irq_enable_reg_r;
            end else if (dph_r.addr == PIC_A_PRIO_LO) begin
                o_hrdata[6:0] = priority_low_bit_r;
            end else if (dph_r.addr == PIC_A_PRIO_HI) begin
                o_hrdata[6:0] = priority_high_bit_r;
            end else if (dph_r.addr == PIC_A_SERVICE) begin
                o_hrdata[3:0] = in_service_r;
            end else if (dph_r.addr == PIC_A_STATUS) begin
                o_hrdata[6:0] = status_r;
            end else if (dph_r.addr == PIC_A_MASK) begin
                o_hrdata[6:0] = mask_r;
            end else if (dph_r.addr == PIC_A_ADCFLAG) begin
                o_hrdata[0] = conversion_done_flag_r;
            end
        end
    end

    // bit op word: [2:0] bit index, [3] value; touches one enable bit only
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            irq_enable_reg_r <= PIC_EN_RST;
        end else if (wr_en && dph_r.addr == PIC_A_IEN) begin
            irq_enable_reg_r <= i_hwdata[7:0];
        end else if (wr_en && dph_r.addr == PIC_A_BITOP) begin
            irq_enable_reg_r[i_hwdata[2:0]] <= i_hwdata[3];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            priority_low_bit_r  <= 7'h00;
            priority_high_bit_r <= 7'h00;
        end else if (wr_en && dph_r.addr == PIC_A_PRIO_LO) begin
            priority_low_bit_r  <= i_hwdata[6:0];
        end else if (wr_en && dph_r.addr == PIC_A_PRIO_HI) begin
            priority_high_bit_r <= i_hwdata[6:0];
        end
    end

    // done flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            conversion_done_flag_r <= 1'b0;
        end else if (i_conversion_done) begin
            conversion_done_flag_r <= 1'b1;
        end else if (wr_en && dph_r.addr == PIC_A_ADCFLAG && !i_hwdata[0]) begin
            conversion_done_flag_r <= 1'b0;
        end
    end

    // sticky event status: rising edge of each raw request
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            req_prev_r <= 7'h00;
            status_r   <= 7'h00;
            mask_r     <= 7'h00;
        end else begin
            req_prev_r <= raw_req;
            status_r   <= (rd_status ? 7'h00 : status_r) | (raw_req & ~req_prev_r);
            if (wr_en && dph_r.addr == PIC_A_MASK) begin
                mask_r <= i_hwdata[6:0];
            end
        end
    end

    assign o_irq = |(status_r & mask_r);

    done_wins_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_conversion_done |=> conversion_done_flag_r) else $error("done flag lost");
    global_off_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !global_irq_enable |-> !o_core_irq) else $error("irq while global off");
    own_enable_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_core_irq |-> irq_enable_reg_r[grant.src] && raw_req[grant.src]) else $error("bad src");
    top_level_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        in_service_r[3] |-> !o_core_irq) else $error("level 3 preempted");
    no_equal_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_core_irq |-> !in_service_r[grant.level]) else $error("same level preempt");
    vec_map_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        grant.valid |=> o_core_vector == PIC_VEC_BASE + 16'(o_core_src) * PIC_VEC_STEP)
        else $error("vector wrong");
    src_pick_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        grant.valid && gated_req[0] && grant.level == {priority_high_bit_r[0], priority_low_bit_r[0]}
        |-> grant.src == 3'h0) else $error("polling order");
    hi_wins_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        grant.valid && gated_req[6] |-> grant.level >= {priority_high_bit_r[6], priority_low_bit_r[6]})
        else $error("lower level won");
    en_reset_a: assert property (@(posedge i_sys_clk)
        $past(i_reset) |-> irq_enable_reg_r == 8'h00) else $error("enable not reset");
    stat_read_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        rd_status && (raw_req & ~req_prev_r) == 7'h00 |=> status_r == 7'h00)
        else $error("status not cleared");
endmodule : pic_ctrl

/* File: pic_pkg.sv */
// How it works
// - seven request sources are gathered: two external inputs, two timer overflows, two pwm units and the converter.
// - bit 7 of the enable register, when clear, blocks every source whatever its own enable holds.
// - each source has its own enable bit, converter at bit 6 down to external input 0 at bit 0.
// - with the global enable set, each source is gated only by its own enable bit.
// - a source's level is its priority high bit over its priority low bit, 00 lowest to 11 highest.
// - a routine in service is preempted only by a request of strictly higher level.
// - a routine at level 3 is never preempted.
// - of simultaneous requests of different levels, the higher level is granted.
// - among equal levels, external input 0 wins, then timer 0, external input 1, timer 1, pwm 0, pwm 1, converter.
// - vectors are 0003h, 000bh, 0013h, 001bh, 0023h, 002bh and 0033h in polling order.
// - the enable register resets to zero and each of its bits can be written on its own.
// - the converter done flag is set by hardware, requests an interrupt and is cleared only by software.
package pic_pkg;
    localparam int          PIC_NSRC      = 7;
    localparam int          PIC_NLVL      = 4;
    localparam int          PIC_GLOBAL_EN = 7;
    localparam int          PIC_SRC_ADC   = 6;
    localparam logic [7:0]  PIC_EN_RST    = 8'h00;
    localparam logic [7:0]  PIC_ZERO8     = 8'h00;
    // register indices; a priority offset is not word aligned, so every register
    // sits as one whole word at four times its index on the bus
    localparam logic [11:0] PIC_I_IEN     = 12'h0a8;
    localparam logic [11:0] PIC_I_PRIO_LO = 12'h0b8;
    localparam logic [11:0] PIC_I_PRIO_HI = 12'h0b7;
    localparam logic [11:0] PIC_I_BITOP   = 12'h100;
    localparam logic [11:0] PIC_I_SERVICE = 12'h104;
    localparam logic [11:0] PIC_I_ACK     = 12'h108;
    localparam logic [11:0] PIC_I_STATUS  = 12'h10c;
    localparam logic [11:0] PIC_I_MASK    = 12'h110;
    localparam logic [11:0] PIC_I_ADCFLAG = 12'h114;
    // byte addresses on the bus
    localparam logic [11:0] PIC_A_IEN     = PIC_I_IEN << 2;
    localparam logic [11:0] PIC_A_PRIO_LO = PIC_I_PRIO_LO << 2;
    localparam logic [11:0] PIC_A_PRIO_HI = PIC_I_PRIO_HI << 2;
    localparam logic [11:0] PIC_A_BITOP   = PIC_I_BITOP << 2;
    localparam logic [11:0] PIC_A_SERVICE = PIC_I_SERVICE << 2;
    localparam logic [11:0] PIC_A_ACK     = PIC_I_ACK << 2;
    localparam logic [11:0] PIC_A_STATUS  = PIC_I_STATUS << 2;
    localparam logic [11:0] PIC_A_MASK    = PIC_I_MASK << 2;
    localparam logic [11:0] PIC_A_ADCFLAG = PIC_I_ADCFLAG << 2;
    localparam logic [1:0]  PIC_HTRANS_NS = 2'b10;
    localparam logic [2:0]  PIC_HSIZE_W   = 3'b010;
    localparam logic [15:0] PIC_VEC_BASE  = 16'h0003;
    localparam logic [15:0] PIC_VEC_STEP  = 16'h0008;

    typedef struct packed {
        logic       valid;
        logic [2:0] src;
        logic [1:0] level;
        logic [15:0] vector;
    } pic_grant_t;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [11:0] addr;
    } pic_bus_req_t;
endpackage : pic_pkg

/* File: pic_arbiter.sv */
`timescale 1ns/10ps
module pic_arbiter #(
    parameter int NSRC = 7
) (
    input  wire logic [NSRC-1:0]   i_req,
    input  wire logic [NSRC-1:0]   i_prio_hi,
    input  wire logic [NSRC-1:0]   i_prio_lo,
    output pic_pkg::pic_grant_t    o_grant
);
    import pic_pkg::*;
    always_comb begin
        logic [1:0] best;
        best    = 2'b00;
        o_grant = '0;
        // walk from the converter down so the lowest index wins ties
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (i_req[i] && (!o_grant.valid || {i_prio_hi[i], i_prio_lo[i]} >= best)) begin
                best           = {i_prio_hi[i], i_prio_lo[i]};
                o_grant.valid  = 1'b1;
                o_grant.src    = 3'(i);
                o_grant.level  = best;
                o_grant.vector = PIC_VEC_BASE + 16'(i) * PIC_VEC_STEP;
            end
        end
    end
endmodule : pic_arbiter

/* File: pic_sync.sv */
`timescale 1ns/10ps
module pic_sync #(
    parameter int W = 2
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : pic_sync

/* File: pic_core_model.sv */
`timescale 1ns/10ps
module pic_core_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_irq,
    input  wire logic [2:0]  i_src,
    input  wire logic [15:0] i_vec,
    input  wire logic [3:0]  i_lat,
    input  wire logic        i_ret,
    output logic             o_take,
    output logic             o_reti,
    output logic [2:0]       o_src,
    output logic [15:0]      o_vec,
    output int               o_n
);
    int wait_r;
    // the core answers after i_lat+2 cycles of steady request, so the lagging vector has settled
    always_ff @(posedge i_sys_clk) begin
        o_take <= 1'b0;
        o_reti <= i_ret;
        if (i_reset) begin
            wait_r <= 0;
            o_n    <= 0;
        end else if (i_irq && !o_take) begin
            wait_r <= wait_r + 1;
            if (wait_r >= int'(i_lat) + 1) begin
                o_take <= 1'b1;
                o_src  <= i_src;
                o_vec  <= i_vec;
                o_n    <= o_n + 1;
                wait_r <= 0;
            end
        end else begin
            wait_r <= 0;
        end
    end
endmodule : pic_core_model

/* File: prioritized_interrupt_controller_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module prioritized_interrupt_controller_bench;
    import pic_pkg::*;
    logic        clk, rst, hsel, hwrite, cdone, ret, hreadyout, hresp, cirq, irq, take, reti;
    logic [1:0]  htrans;
    logic [2:0]  hsize, csrc, m_src;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] cvec, m_vec;
    logic [5:0]  src;
    logic [3:0]  lat;
    logic [6:0]  h, l;
    logic [7:0]  en;
    int          seed, n_fail, cmp_count, n_seen, cyc, m_n, e;

    pic_ctrl dut_u (.i_sys_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_ext_irq_in_zero(src[0]), .i_timer0_overflow_flag(src[1]),
        .i_ext_irq_in_one(src[2]), .i_timer1_overflow_flag(src[3]),
        .i_pwm_unit_zero(src[4]), .i_pwm_unit_one(src[5]), .i_conversion_done(cdone),
        .o_core_irq(cirq), .o_core_vector(cvec), .o_core_src(csrc), .i_core_take(take),
        .i_core_reti(reti), .o_irq(irq));
    pic_core_model core_u (.i_sys_clk(clk), .i_reset(rst), .i_irq(cirq), .i_src(csrc),
        .i_vec(cvec), .i_lat(lat), .i_ret(ret), .o_take(take), .o_reti(reti),
        .o_src(m_src), .o_vec(m_vec), .o_n(m_n));

    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= PIC_HTRANS_NS;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // expected winner: highest level, lowest polling index breaks ties
    function automatic int win(input logic [6:0] a, input logic [6:0] hi, input logic [6:0] lo);
        int b = -1;
        for (int i = 0; i < 7; i++)
            if (a[i] && (b < 0 || {hi[i], lo[i]} > {hi[b], lo[b]})) b = i;
        return b;
    endfunction : win

    task automatic take_chk(input int x);
        int t = 0;
        while (m_n == n_seen && t < 60) begin @(posedge clk); t++; end
        n_seen = m_n;
        `CHK("src", 3'(x), m_src)
        `CHK("vec", PIC_VEC_BASE + 16'(x) * PIC_VEC_STEP, m_vec)
        repeat (3) @(posedge clk);
    endtask : take_chk

    task automatic ret1;
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : ret1

    task automatic conv;
        cdone <= 1'b1;
        @(posedge clk);
        cdone <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : conv

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin n_fail++; stop_test(); end
    end

    initial begin
        {rst, seed} = {1'b1, 32'd49};
        {hsel, hwrite, cdone, ret, htrans, haddr, hwdata, src, lat} = '0;
        hsize = PIC_HSIZE_W;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, PIC_A_IEN, 0); `CHK("ien_rst", PIC_EN_RST, rd[7:0])
        `CHK("hresp", 1'b0, hresp)
        bus(1'b0, PIC_A_ACK, 0); `CHK("unmapped", 32'h0, rd)
        // single bit write: set bit 7 alone
        bus(1'b1, PIC_A_BITOP, 32'h0f);
        bus(1'b0, PIC_A_IEN, 0); `CHK("bit_op", 8'h80, rd[7:0])
        // status and mask: sticky bits, read clears
        bus(1'b1, PIC_A_MASK, 32'h12);
        src <= 6'h13;
        repeat (4) @(posedge clk);
        `CHK("irq_set", 1'b1, irq)
        bus(1'b0, PIC_A_STATUS, 0); `CHK("status", 7'h13, rd[6:0])
        @(posedge clk); `CHK("irq_clr", 1'b0, irq)
        bus(1'b1, PIC_A_MASK, 0);
        src <= 6'h3f; conv();
        `CHK("irq_mask", 1'b0, irq)
        // every source pending while the global enable is clear, then alone
        bus(1'b1, PIC_A_IEN, 32'h7f); repeat (3) @(posedge clk);
        `CHK("ea_off", 1'b0, cirq)
        bus(1'b1, PIC_A_IEN, 32'h80); repeat (3) @(posedge clk);
        `CHK("ea_only", 1'b0, cirq)
        // equal levels: serviced one by one in polling order
        bus(1'b1, PIC_A_IEN, 32'hff);
        for (int k = 0; k < 7; k++) begin
            take_chk(k);
            `CHK("no_same", 1'b0, cirq)
            if (k < 6) src[k] <= 1'b0;
            else begin
                bus(1'b0, PIC_A_ADCFLAG, 0); `CHK("conv_flag", 1'b1, rd[0])
                bus(1'b1, PIC_A_ADCFLAG, 0);
            end
            ret1();
        end
        // one enable at a time, then random enables, levels and core latency
        for (int r = 0; r < 20; r++) begin
            {h, l} = 14'($random(seed));
            en = (r < 7) ? (8'h80 | 8'(1 << r)) : (8'h80 | 8'($random(seed)));
            lat <= 4'($random(seed));
            bus(1'b1, PIC_A_IEN, 0);
            bus(1'b1, PIC_A_PRIO_HI, {25'h0, h});
            bus(1'b1, PIC_A_PRIO_LO, {25'h0, l});
            // let synced pins and the done flag settle before enables open
            src <= 6'h3f; conv();
            bus(1'b1, PIC_A_IEN, {24'h0, en});
            e = win(en[6:0], h, l);
            if (e >= 0) begin
                take_chk(e);
                `CHK("no_pre", 1'b0, cirq)
            end
            src <= 6'h00;
            bus(1'b1, PIC_A_ADCFLAG, 0);
            ret1();
        end
        // level 1 in service, preempted by level 3, which nothing preempts
        lat <= 4'h0;
        bus(1'b1, PIC_A_PRIO_HI, 32'h03);
        bus(1'b1, PIC_A_PRIO_LO, 32'h23);
        bus(1'b1, PIC_A_IEN, 32'hff);
        src <= 6'h20; take_chk(5);
        src <= 6'h21; take_chk(0);
        src <= 6'h23; repeat (8) @(posedge clk);
        `CHK("top_hold", 1'b0, cirq)
        src <= 6'h22; ret1(); take_chk(1);
        src <= 6'h00;
        repeat (3) ret1();
        stop_test();
    end
endmodule : prioritized_interrupt_controller_bench
